// ---- hdl/spdet_core.sv ----
`timescale 1ns/1ps
// Operation
// - read request while receive buffer not empty
// - i2s right-channel read request when data present
// - write request when buffer and shifter empty
// - write request on room, no half-full check
// - i2s write request when room for right
// - one service clears all three write requests
// - errors halt dma when enabled
// - one 9-bit counter, three comparators
// - start enables comparator, clears and runs counter
// - stop disables comparator, others keep counting
// - count to 256 or restart on match
// - counter stops when all comparators disabled
// - start with stop: event, stay enabled, restart
// - delays pick preset or comparator value
// - sequencer counter runs independently
// - response timeout event after compare value
// - restart gives interval, restarted status flag
// - break event after line active long enough
// - start delay, then select and setup, then shift
// - character gap before each later character
// - transmit waits for comparator 1 after receive
// - interrupt from any enabled flag
module spdet_core #(
    parameter int BAUD_W = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [BAUD_W-1:0] baud_div,
    input wire logic i2s_mode,
    input wire logic rx_buf_not_empty,
    input wire logic rx_right_present,
    input wire logic tx_buf_full,
    input wire logic tx_buf_empty,
    input wire logic tx_shift_empty,
    input wire logic tx_right_expected,
    input wire logic dma_write_served,
    input wire logic rx_error,
    input wire logic error_halts_dma,
    input wire logic dma_resume,
    output logic dma_rx_req,
    output logic dma_rx_right_req,
    output logic dma_tx_empty_req,
    output logic tx_room_request,
    output logic dma_tx_right_req,
    input wire logic transmit_frame_end,
    input wire logic receive_frame_end,
    input wire logic receive_line_active,
    input wire logic receive_line_inactive,
    input wire logic tx_start,
    input wire logic [7:0] comparator_value0,
    input wire logic [7:0] comparator_value1,
    input wire logic [7:0] comparator_value2,
    input wire logic [2:0] comparator_start_source0,
    input wire logic [2:0] comparator_start_source1,
    input wire logic [2:0] comparator_start_source2,
    input wire logic [2:0] comparator_stop_source0,
    input wire logic [2:0] comparator_stop_source1,
    input wire logic [2:0] comparator_stop_source2,
    input wire logic [2:0] comparator_restart_enable,
    output logic comparator0_event,
    output logic comparator1_event,
    output logic comparator2_event,
    output logic counter_was_restarted,
    output logic [2:0] event_flags,
    input wire logic [2:0] event_flag_clear,
    input wire logic [2:0] event_irq_enable,
    input wire logic other_flags_pending,
    output logic irq,
    input wire logic [2:0] transmit_start_delay,
    input wire logic [2:0] select_setup_delay,
    input wire logic [2:0] character_gap_delay,
    input wire logic [2:0] select_hold_delay,
    input wire logic auto_select_drive,
    input wire logic transmit_after_receive_trigger,
    input wire logic char_done,
    output logic tx_shift_go,
    output logic select_out,
    output logic seq_busy
);

    initial begin
        if (BAUD_W < 1 || BAUD_W > 32) begin
            $error("spdet_core: BAUD_W out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud-time tick

    logic [BAUD_W-1:0] baud_cnt_reg;
    logic [BAUD_W-1:0] baud_cnt_next;
    wire baud_tick = (baud_cnt_reg == baud_div);

    assign baud_cnt_next = baud_tick ? BAUD_W'(0) : baud_cnt_reg + BAUD_W'(1);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            baud_cnt_reg <= BAUD_W'(spdet_pkg::BAUD_CNT_RESET);
        end else begin
            baud_cnt_reg <= baud_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dma requests

    logic halted_reg;
    logic halted_next;
    logic tx_empty_req_reg;
    logic tx_room_req_reg;
    logic tx_right_req_reg;

    assign halted_next = (rx_error && error_halts_dma) ? 1'b1 : (dma_resume ? 1'b0 : halted_reg);

    wire empty_cond = tx_buf_empty && tx_shift_empty && !halted_reg;
    wire room_cond = !tx_buf_full && !halted_reg;
    wire right_cond = i2s_mode && room_cond && tx_right_expected;

    assign dma_rx_req = rx_buf_not_empty && !halted_reg;
    assign dma_rx_right_req = i2s_mode && rx_right_present && !halted_reg;
    assign dma_tx_empty_req = tx_empty_req_reg;
    assign tx_room_request = tx_room_req_reg;
    assign dma_tx_right_req = tx_right_req_reg;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            halted_reg <= 1'b0;
            tx_empty_req_reg <= 1'b0;
            tx_room_req_reg <= 1'b0;
            tx_right_req_reg <= 1'b0;
        end else begin
            halted_reg <= halted_next;
            tx_empty_req_reg <= empty_cond && !dma_write_served;
            tx_room_req_reg <= room_cond && !dma_write_served;
            tx_right_req_reg <= right_cond && !dma_write_served;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general timer

    function automatic logic start_hit(input logic [2:0] sel);
        start_hit = (sel == spdet_pkg::START_TX_END && transmit_frame_end)
            || (sel == spdet_pkg::START_RX_END && receive_frame_end)
            || (sel == spdet_pkg::START_RX_ACT && receive_line_active)
            || (sel == spdet_pkg::START_RX_INACT && receive_line_inactive);
    endfunction : start_hit

    function automatic logic stop_hit(input logic [2:0] sel, input logic own);
        stop_hit = (sel == spdet_pkg::STOP_OWN_EVENT && own)
            || (sel == spdet_pkg::STOP_RX_ACT && receive_line_active)
            || (sel == spdet_pkg::STOP_RX_INACT && receive_line_inactive)
            || (sel == spdet_pkg::STOP_TX_START && tx_start);
    endfunction : stop_hit

    wire [7:0] cmp_val [3];
    wire [2:0] start_sel [3];
    wire [2:0] stop_sel [3];
    assign cmp_val[0] = comparator_value0;
    assign cmp_val[1] = comparator_value1;
    assign cmp_val[2] = comparator_value2;
    assign start_sel[0] = comparator_start_source0;
    assign start_sel[1] = comparator_start_source1;
    assign start_sel[2] = comparator_start_source2;
    assign stop_sel[0] = comparator_stop_source0;
    assign stop_sel[1] = comparator_stop_source1;
    assign stop_sel[2] = comparator_stop_source2;

    logic [spdet_pkg::CNT_W-1:0] cnt_reg;
    logic [spdet_pkg::CNT_W-1:0] cnt_next;
    logic [2:0] en_reg;
    logic [2:0] en_next;
    logic [2:0] ev_reg;
    logic [2:0] match;
    logic [2:0] start_now;
    logic [2:0] stop_now;
    logic [2:0] both_now;
    logic [2:0] restart_now;
    logic [2:0] flags_reg;
    logic restarted_reg;
    logic irq_reg;

    wire counting = (|en_reg) && (cnt_reg != spdet_pkg::CNT_FULL);
    wire [spdet_pkg::CNT_W-1:0] cnt_inc = cnt_reg + spdet_pkg::CNT_W'(1);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cmp
            assign match[gi] = en_reg[gi] && counting && baud_tick
                && (cnt_inc == {1'b0, cmp_val[gi]});
            assign start_now[gi] = start_hit(start_sel[gi]);
            assign stop_now[gi] = stop_hit(stop_sel[gi], match[gi]);
            assign both_now[gi] = start_now[gi] && stop_now[gi];
            assign restart_now[gi] = match[gi] && comparator_restart_enable[gi];
            assign en_next[gi] = start_now[gi] ? 1'b1 :
                (((stop_now[gi] && !restart_now[gi])
                || (start_sel[gi] == spdet_pkg::START_DISABLE)) ? 1'b0 : en_reg[gi]);
        end
    endgenerate

    assign cnt_next = (|start_now) ? spdet_pkg::CNT_RESET :
        ((|restart_now) ? spdet_pkg::CNT_RELOAD :
        ((counting && baud_tick) ? cnt_inc : cnt_reg));

    wire [2:0] ev_now = match | both_now;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_reg <= spdet_pkg::CNT_RESET;
            en_reg <= 3'h0;
            ev_reg <= 3'h0;
            flags_reg <= 3'h0;
            restarted_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            en_reg <= en_next;
            ev_reg <= ev_now;
            flags_reg <= ev_now | (flags_reg & ~event_flag_clear);
            restarted_reg <= (|restart_now) ? 1'b1 : ((|start_now) ? 1'b0 : restarted_reg);
            irq_reg <= (|(flags_reg & event_irq_enable)) || other_flags_pending;
        end
    end

    assign comparator0_event = ev_reg[0];
    assign comparator1_event = ev_reg[1];
    assign comparator2_event = ev_reg[2];
    assign event_flags = flags_reg;
    assign counter_was_restarted = restarted_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // transmit sequencer

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_TRIG,
        SEQ_DELAY,
        SEQ_SETUP,
        SEQ_SHIFT,
        SEQ_GAP,
        SEQ_HOLD
    } spdet_seq_e;

    function automatic logic [7:0] delay_of(input logic [2:0] sel);
        case (sel)
            spdet_pkg::DLY_PRESET0: delay_of = spdet_pkg::PRESET_0;
            spdet_pkg::DLY_PRESET1: delay_of = spdet_pkg::PRESET_1;
            spdet_pkg::DLY_PRESET2: delay_of = spdet_pkg::PRESET_2;
            spdet_pkg::DLY_PRESET3: delay_of = spdet_pkg::PRESET_3;
            spdet_pkg::DLY_PRESET7: delay_of = spdet_pkg::PRESET_7;
            spdet_pkg::DLY_CMP0: delay_of = comparator_value0;
            spdet_pkg::DLY_CMP1: delay_of = comparator_value1;
            default: delay_of = comparator_value2;
        endcase
    endfunction : delay_of

    spdet_seq_e seq_reg;
    spdet_seq_e seq_next;
    logic [7:0] seq_cnt_reg;
    logic [7:0] seq_cnt_next;
    logic [7:0] target;
    logic go_reg;
    logic go_next;
    logic sel_reg;
    logic sel_next;

    wire seq_done = (seq_cnt_reg == target);

    always_comb begin
        seq_next = seq_reg;
        go_next = 1'b0;
        target = spdet_pkg::PRESET_0;
        case (seq_reg)
            SEQ_IDLE: begin
                if (!tx_buf_empty) begin
                    seq_next = transmit_after_receive_trigger ? SEQ_TRIG : SEQ_DELAY;
                end
            end
            SEQ_TRIG: begin
                if (ev_reg[1]) begin
                    seq_next = SEQ_DELAY;
                end
            end
            SEQ_DELAY: begin
                target = delay_of(transmit_start_delay);
                if (seq_done) begin
                    seq_next = SEQ_SETUP;
                end
            end
            SEQ_SETUP: begin
                target = delay_of(select_setup_delay);
                if (seq_done) begin
                    seq_next = SEQ_SHIFT;
                    go_next = 1'b1;
                end
            end
            SEQ_SHIFT: begin
                if (char_done) begin
                    seq_next = tx_buf_empty ? SEQ_HOLD : SEQ_GAP;
                end
            end
            SEQ_GAP: begin
                target = delay_of(character_gap_delay);
                if (seq_done) begin
                    seq_next = SEQ_SHIFT;
                    go_next = 1'b1;
                end
            end
            SEQ_HOLD: begin
                target = delay_of(select_hold_delay);
                if (seq_done) begin
                    seq_next = SEQ_IDLE;
                end
            end
            default: seq_next = SEQ_IDLE;
        endcase
    end

    assign seq_cnt_next = (seq_next != seq_reg) ? spdet_pkg::SEQ_CNT_RESET :
        (baud_tick ? seq_cnt_reg + 8'h01 : seq_cnt_reg);

    assign sel_next = (seq_next == SEQ_SETUP) || (seq_next == SEQ_SHIFT)
        || (auto_select_drive && ((seq_next == SEQ_GAP) || (seq_next == SEQ_HOLD)));

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            seq_reg <= SEQ_IDLE;
            seq_cnt_reg <= spdet_pkg::SEQ_CNT_RESET;
            go_reg <= 1'b0;
            sel_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            seq_cnt_reg <= seq_cnt_next;
            go_reg <= go_next;
            sel_reg <= sel_next;
        end
    end

    assign tx_shift_go = go_reg;
    assign select_out = sel_reg;
    assign seq_busy = (seq_reg != SEQ_IDLE);

endmodule : spdet_core

// ---- hdl/spdet_pkg.sv ----
package spdet_pkg;
    // delay selector codes for the transmit sequencer settings
    localparam logic [2:0] DLY_PRESET0 = 3'h0;
    localparam logic [2:0] DLY_PRESET1 = 3'h1;
    localparam logic [2:0] DLY_PRESET2 = 3'h2;
    localparam logic [2:0] DLY_PRESET3 = 3'h3;
    localparam logic [2:0] DLY_PRESET7 = 3'h4;
    localparam logic [2:0] DLY_CMP0 = 3'h5;
    localparam logic [2:0] DLY_CMP1 = 3'h6;
    localparam logic [2:0] DLY_CMP2 = 3'h7;
    localparam logic [7:0] PRESET_0 = 8'h00;
    localparam logic [7:0] PRESET_1 = 8'h01;
    localparam logic [7:0] PRESET_2 = 8'h02;
    localparam logic [7:0] PRESET_3 = 8'h03;
    localparam logic [7:0] PRESET_7 = 8'h07;
    // comparator start source codes
    localparam logic [2:0] START_DISABLE = 3'h0;
    localparam logic [2:0] START_TX_END = 3'h1;
    localparam logic [2:0] START_RX_END = 3'h2;
    localparam logic [2:0] START_RX_ACT = 3'h3;
    localparam logic [2:0] START_RX_INACT = 3'h4;
    // comparator stop source codes
    localparam logic [2:0] STOP_OWN_EVENT = 3'h0;
    localparam logic [2:0] STOP_RX_ACT = 3'h1;
    localparam logic [2:0] STOP_RX_INACT = 3'h2;
    localparam logic [2:0] STOP_TX_START = 3'h3;
    // counter limits and reset values
    localparam int CNT_W = 9;
    localparam logic [8:0] CNT_FULL = 9'h100;
    localparam logic [8:0] CNT_RELOAD = 9'h1ff;
    localparam logic [8:0] CNT_RESET = 9'h000;
    localparam logic [7:0] SEQ_CNT_RESET = 8'h00;
    localparam logic [15:0] BAUD_CNT_RESET = 16'h0000;
endpackage : spdet_pkg

// ---- tb/spdet_assertions.sv ----
`timescale 1ns/1ps
module spdet_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic rx_buf_not_empty,
    input wire logic tx_buf_full,
    input wire logic tx_buf_empty,
    input wire logic tx_shift_empty,
    input wire logic dma_write_served,
    input wire logic rx_error,
    input wire logic error_halts_dma,
    input wire logic dma_rx_req,
    input wire logic dma_tx_empty_req,
    input wire logic tx_room_request,
    input wire logic comparator0_event,
    input wire logic [2:0] event_flags,
    input wire logic [2:0] event_irq_enable,
    input wire logic irq,
    input wire logic tx_shift_go,
    input wire logic select_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    property p_rx; !rx_buf_not_empty |-> !dma_rx_req; endproperty
    a_rx: assert property (p_rx) else $error("rx request without data");
    property p_empty; !(tx_buf_empty && tx_shift_empty) |=> !dma_tx_empty_req; endproperty
    a_empty: assert property (p_empty) else $error("empty request too early");
    property p_room; tx_buf_full |=> !tx_room_request; endproperty
    a_room: assert property (p_room) else $error("room request while full");
    property p_served; dma_write_served |=> !(dma_tx_empty_req || tx_room_request); endproperty
    a_served: assert property (p_served) else $error("write request not cleared");
    property p_halt; rx_error && error_halts_dma |=> !dma_rx_req ##1 !tx_room_request; endproperty
    a_halt: assert property (p_halt) else $error("requests not halted");
    property p_flag; comparator0_event |-> event_flags[0]; endproperty
    a_flag: assert property (p_flag) else $error("event without flag");
    property p_irq; event_flags[0] && event_irq_enable[0] |=> irq; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_go; tx_shift_go |-> select_out && $past(select_out); endproperty
    a_go: assert property (p_go) else $error("shift before select setup");
    ////////////////////////////////////////////////////////////////////////////////
    c_evt: cover property (comparator0_event);
    c_served: cover property (dma_write_served ##1 !tx_room_request);
    c_go: cover property (tx_shift_go);
endmodule : spdet_checker

bind spdet_core spdet_checker i_chk (.*);

// ---- tb/spdet_dma_model.sv ----
`timescale 1ns/1ps
module spdet_dma_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serve_en,
    input wire logic dma_rx_req,
    input wire logic tx_room_request,
    output logic dma_write_served
);
    // one write source only, reads served first
    wire take_write = serve_en && tx_room_request && !dma_rx_req;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dma_write_served <= 1'b0;
        end else begin
            dma_write_served <= take_write && !dma_write_served;
        end
    end
endmodule : spdet_dma_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] baud_div = 16'h0000;
    logic i2s_mode, rx_buf_not_empty, rx_right_present, tx_buf_full, tx_buf_empty;
    logic tx_shift_empty, tx_right_expected, rx_error, error_halts_dma, dma_resume;
    logic dma_rx_req, dma_rx_right_req, dma_tx_empty_req, tx_room_request, dma_tx_right_req;
    logic transmit_frame_end, receive_frame_end, receive_line_active, receive_line_inactive;
    logic tx_start, comparator0_event, comparator1_event, comparator2_event, serve_en;
    logic counter_was_restarted, other_flags_pending, irq, auto_select_drive, char_done;
    logic transmit_after_receive_trigger, tx_shift_go, select_out, seq_busy, dma_write_served;
    logic [7:0] comparator_value0, comparator_value1, comparator_value2;
    logic [2:0] comparator_start_source0, comparator_start_source1, comparator_start_source2;
    logic [2:0] comparator_stop_source0, comparator_stop_source1, comparator_stop_source2;
    logic [2:0] comparator_restart_enable, event_flags, event_flag_clear, event_irq_enable;
    logic [2:0] transmit_start_delay, select_setup_delay, character_gap_delay, select_hold_delay;
    int fails = 0;
    int checked = 0;
    wire [5:0] mon = {!seq_busy, tx_shift_go, select_out, comparator2_event,
        comparator1_event, comparator0_event};
    spdet_core i_dut (.*);
    spdet_dma_model i_dma (.*);
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic wait_on(input int k, output int n);
        n = 0;
        while (mon[k] !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
    endtask : wait_on
    task automatic fire(input logic [2:0] s);
        transmit_frame_end = (s == spdet_pkg::START_TX_END);
        receive_frame_end = (s == spdet_pkg::START_RX_END);
        receive_line_active = (s == spdet_pkg::START_RX_ACT);
        receive_line_inactive = (s == spdet_pkg::START_RX_INACT);
        cyc(1);
        {transmit_frame_end, receive_frame_end, receive_line_active, receive_line_inactive} = 4'h0;
    endtask : fire
    task automatic conclude();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_dma();
        {rx_buf_not_empty, i2s_mode, rx_right_present, tx_right_expected} = 4'hf;
        cyc(2);
        chk(dma_rx_req === 1'b1, "rx request");
        chk(dma_rx_right_req === 1'b1, "rx right request");
        chk(dma_tx_right_req === 1'b1, "tx right request");
        chk(dma_tx_empty_req === 1'b1, "empty request");
        rx_buf_not_empty = 1'b0;
        i2s_mode = 1'b0;
        serve_en = 1'b1;
        cyc(1);
        chk(dma_rx_right_req === 1'b0, "right request outside i2s");
        serve_en = 1'b0;
        cyc(1);
        chk({tx_room_request, dma_tx_empty_req} === 2'b00, "requests not cleared");
        cyc(1);
        chk(tx_room_request === 1'b1, "room request back");
        tx_shift_empty = 1'b0;
        cyc(2);
        chk({dma_tx_empty_req, tx_room_request} === 2'b01, "shifter busy");
        tx_shift_empty = 1'b1;
        tx_buf_full = 1'b1;
        cyc(2);
        chk({dma_tx_empty_req, tx_room_request} === 2'b10, "buffer full");
        {tx_buf_full, error_halts_dma, rx_error, rx_buf_not_empty} = 4'h7;
        cyc(1);
        rx_error = 1'b0;
        cyc(1);
        chk({dma_rx_req, tx_room_request} === 2'b00, "halt");
        dma_resume = 1'b1;
        cyc(1);
        dma_resume = 1'b0;
        chk(dma_rx_req === 1'b1, "resume");
        {error_halts_dma, rx_error} = 2'b01;
        cyc(1);
        rx_error = 1'b0;
        chk(dma_rx_req === 1'b1, "halt while disabled");
        rx_buf_not_empty = 1'b0;
        $display("test_dma done");
    endtask : test_dma
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_timer();
        int n;
        event_irq_enable = 3'h1;
        comparator_value0 = 8'h08;
        comparator_start_source0 = spdet_pkg::START_TX_END;
        comparator_stop_source0 = spdet_pkg::STOP_RX_ACT;
        fire(spdet_pkg::START_TX_END);
        wait_on(0, n);
        chk(n == 8, "response timeout");
        chk(event_flags[0] === 1'b1, "flag");
        event_flag_clear = 3'h1;
        cyc(1);
        event_flag_clear = 3'h0;
        chk({comparator0_event, irq} === 2'b01, "pulse or irq");
        cyc(1);
        chk({event_flags[0], irq} === 2'b00, "flag clear");
        comparator_value1 = 8'h0c;
        comparator_start_source1 = spdet_pkg::START_TX_END;
        fire(spdet_pkg::START_TX_END);
        cyc(4);
        fire(spdet_pkg::START_RX_ACT);
        wait_on(1, n);
        chk(n == 7 && event_flags[0] === 1'b0, "stop or shared counter");
        for (int s = 1; s < 5; s++) begin
            comparator_start_source1 = 3'(s);
            comparator_stop_source1 = (s == 4) ? spdet_pkg::STOP_OWN_EVENT : spdet_pkg::STOP_RX_INACT;
            cyc(1);
            fire(3'(s));
            wait_on(1, n);
            chk(n == 12, "start source or break");
        end
        comparator_start_source0 = spdet_pkg::START_DISABLE;
        comparator_value1 = 8'h03;
        comparator_start_source1 = spdet_pkg::START_RX_END;
        comparator_stop_source1 = spdet_pkg::STOP_RX_ACT;
        comparator_restart_enable = 3'h2;
        fire(spdet_pkg::START_RX_END);
        chk(counter_was_restarted === 1'b0, "restart status");
        wait_on(1, n);
        chk(n == 3, "first interval");
        cyc(1);
        wait_on(1, n);
        chk(n == 3 && counter_was_restarted === 1'b1, "next interval");
        comparator_start_source1 = spdet_pkg::START_DISABLE;
        cyc(1);
        wait_on(1, n);
        chk(n == 300, "interval not stopped");
        comparator_value2 = 8'h05;
        comparator_start_source2 = spdet_pkg::START_RX_INACT;
        comparator_stop_source2 = spdet_pkg::STOP_RX_INACT;
        fire(spdet_pkg::START_RX_INACT);
        chk(comparator2_event === 1'b1, "start with stop");
        cyc(1);
        wait_on(2, n);
        chk(n == 4, "stays enabled");
        comparator_start_source2 = spdet_pkg::START_DISABLE;
        comparator_value0 = 8'h04;
        comparator_start_source0 = spdet_pkg::START_TX_END;
        baud_div = 16'h0001;
        fire(spdet_pkg::START_TX_END);
        wait_on(0, n);
        chk(n >= 7 && n <= 9, "baud rate");
        {baud_div, event_irq_enable, other_flags_pending} = 20'h00001;
        cyc(2);
        chk(irq === 1'b1, "other flags");
        other_flags_pending = 1'b0;
        cyc(2);
        chk(irq === 1'b0, "masked flags");
        $display("test_timer done");
    endtask : test_timer
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_seq();
        int a, b;
        int d [6] = '{0, 1, 2, 3, 7, 4};
        int s [6] = '{0, 1, 2, 3, 7, 2};
        {comparator_value0, comparator_value1} = 16'h0402;
        for (int i = 0; i < 6; i++) begin
            transmit_start_delay = 3'(i);
            select_setup_delay = (i == 5) ? spdet_pkg::DLY_CMP1 : 3'(i);
            tx_buf_empty = 1'b0;
            wait_on(3, a);
            wait_on(4, b);
            chk(a == d[i] + 2 && b == s[i] + 1, "delays");
            auto_select_drive = (i == 5);
            character_gap_delay = spdet_pkg::DLY_PRESET3;
            tx_buf_empty = (i != 5);
            char_done = 1'b1;
            cyc(1);
            char_done = 1'b0;
            if (i == 5) begin
                wait_on(4, b);
                chk(b == 4 && select_out === 1'b1, "gap");
                tx_buf_empty = 1'b1;
                char_done = 1'b1;
                cyc(1);
                char_done = 1'b0;
            end
            tx_buf_empty = 1'b1;
            wait_on(5, a);
            chk(select_out === 1'b0 && a < 300, "select released");
        end
        {transmit_start_delay, select_setup_delay, comparator_restart_enable} = '0;
        comparator_start_source1 = spdet_pkg::START_RX_END;
        comparator_stop_source1 = spdet_pkg::STOP_OWN_EVENT;
        transmit_after_receive_trigger = 1'b1;
        tx_buf_empty = 1'b0;
        cyc(4);
        chk(select_out === 1'b0 && seq_busy === 1'b1, "waits for receive");
        fire(spdet_pkg::START_RX_END);
        wait_on(3, a);
        chk(a == 4, "transmit after receive");
        wait_on(4, b);
        tx_buf_empty = 1'b1;
        char_done = 1'b1;
        cyc(1);
        {char_done, transmit_after_receive_trigger} = 2'b00;
        wait_on(5, a);
        chk(a < 300, "trigger sequence ends");
        $display("test_seq done");
    endtask : test_seq
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {i2s_mode, rx_buf_not_empty, rx_right_present, tx_buf_full, tx_right_expected,
            rx_error, error_halts_dma, dma_resume, transmit_frame_end, receive_frame_end,
            receive_line_active, receive_line_inactive, tx_start, other_flags_pending,
            auto_select_drive, transmit_after_receive_trigger, char_done, serve_en} = '0;
        {tx_buf_empty, tx_shift_empty} = 2'b11;
        {comparator_value0, comparator_value1, comparator_value2} = '0;
        {comparator_start_source0, comparator_start_source1, comparator_start_source2} = '0;
        {comparator_stop_source0, comparator_stop_source1, comparator_stop_source2} = '0;
        {comparator_restart_enable, event_flag_clear, event_irq_enable} = '0;
        {transmit_start_delay, select_setup_delay, character_gap_delay, select_hold_delay} = '0;
        cyc(4);
        rst_b = 1'b1;
        test_dma();
        test_timer();
        test_seq();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        conclude();
    end
endmodule : tb_top
